// [core/pfb_pkg.sv]
package pfb_pkg;
  localparam int MAX_CELLS = 8;
  localparam int VW = 12;
  localparam int CLK_HZ = 250000000;
  localparam int US_PER_S = 1000000;
  localparam int CYC_PER_US = CLK_HZ / US_PER_S;
  localparam int US_PER_MS = 1000;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam int HYST_MV = 117;
  // Cell code = mV * 4095 * 3 / (1800 * 8); full scale 4.8 V.
  localparam logic [VW-1:0] HYST_CODE = VW'((HYST_MV * 4095 * 3) / (1800 * 8));
  localparam logic [1:0] SCALE_US = 2'h0;
  localparam logic [1:0] SCALE_MS = 2'h1;
  localparam logic [1:0] SCALE_S = 2'h2;
  localparam logic [1:0] SCALE_MIN = 2'h3;
  localparam logic [VW-1:0] LO_START = 12'hFFF;

  typedef logic [MAX_CELLS-1:0][VW-1:0] pfb_cells_t;

  typedef struct packed {
    logic chg;
    logic dsc;
    logic pchg;
  } pfb_sw_t;

  typedef struct packed {
    logic [VW-1:0] min_delta;
    logic [VW-1:0] max_delta;
    logic [VW-1:0] floor_v;
    logic [VW-1:0] ceiling_v;
    logic [9:0]    on_cnt;
    logic [1:0]    on_scale;
    logic [9:0]    off_cnt;
    logic [1:0]    off_scale;
    logic          in_chg;
    logic          in_dsc;
    logic          at_full;
  } pfb_bal_cfg_t;

  typedef enum logic [1:0] {
    BAL_IDLE = 2'b00,
    BAL_ON   = 2'b01,
    BAL_OFF  = 2'b10
  } pfb_bal_st_t;

  typedef struct packed {
    pfb_sw_t        sw;
    pfb_bal_st_t    bst;
    logic [11:0]    tmr;
    logic [7:0]     cyc;
    logic [9:0]     us;
    logic [9:0]     ms;
    logic [5:0]     sec;
    logic [VW-1:0]  lo;
    logic [VW-1:0]  hi;
    logic [MAX_CELLS-1:0] needs;
    logic [MAX_CELLS-1:0] sel;
    logic [MAX_CELLS-1:0] bal;
    logic           spread;
    logic           uv;
    logic           ov;
  } pfb_state_t;
endpackage

// [core/pfb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: Host override bit set lets host switch pack switches, protections aside.
// RULE2: Under host override, short circuit forces switches off; host restores.
// RULE3: Under host override, internal over-temperature forces switches off; host restores.
// RULE4: Under host override, overvoltage lockout forces charge and precharge off.
// RULE5: Under host override, open sense wire forces switches off; host restores.
// RULE6: Force-off input high holds all switches off; host restores afterwards.
// RULE7: Sleep turns switches off; after wake the host turns them on.
// RULE8: Host scan override keeps only short-circuit and force-off control in device; code also clears switches on sleep.
// RULE9: Balance evaluated per scan; outputs only in on period, off in off.
// RULE10: At scan end, recompute lowest and highest voltage of used cells.
// RULE11: Flag each cell exceeding lowest voltage by more than minimum delta.
// RULE12: Cell above lowest by maximum delta sets spread fault, stops balancing.
// RULE13: Highest below floor sets undervolt flag; clears 117mV above floor.
// RULE14: Lowest above ceiling sets overvolt flag; clears 117mV below ceiling.
// RULE15: Only cells within configured count are evaluated or driven.
// RULE16: Cell selection latched at on-period start, fixed for whole period.
// RULE17: Any external temperature outside cold/hot limits disables balancing.
// RULE18: Balance on charge-only or discharge-only current per selected direction bits.
// RULE19: Both directions selected balances on either current, never without current.
// RULE20: Full-charge bit with end-of-charge state balances regardless of current.
// RULE21: All direction bits zero, or force-off input, means no balancing.
// RULE22: Separate 12-bit on/off timers, 10-bit count, scale us/ms/s/min.
// RULE23: Without host override, temperature faults drop matching switch, stop balancing.
// RULE24: On and off periods alternate while enabled; off expiry restarts on.
module pfb_top
  import pfb_pkg::*;
#(
  parameter int N_TEMP = 2
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_host_switch_override,
  input  wire logic               i_host_scan_override,
  input  wire logic               i_host_sw_wr,
  input  wire pfb_sw_t            i_host_sw,
  input  wire pfb_sw_t            i_auto_sw_req,
  input  wire logic               i_chg_temp_fault,
  input  wire logic               i_dsc_temp_fault,
  input  wire logic               i_short_circuit,
  input  wire logic               i_int_over_temp,
  input  wire logic               i_overvoltage_lockout,
  input  wire logic               i_open_wire,
  input  wire logic               i_force_switches_off_input,
  input  wire logic               i_sleep,
  input  wire logic               i_charging_detected,
  input  wire logic               i_discharging_detected,
  input  wire logic               i_end_of_charge,
  input  wire logic               i_bal_enable,
  input  wire logic [3:0]         i_cell_count,
  input  wire logic               i_scan_done,
  input  wire pfb_cells_t         i_cell_v,
  input  wire logic [N_TEMP*VW-1:0] i_ext_temp,
  input  wire logic [VW-1:0]      i_balance_cold_limit,
  input  wire logic [VW-1:0]      i_balance_hot_limit,
  input  wire pfb_bal_cfg_t       i_bal_cfg,
  output logic                    o_switch_chg,
  output logic                    o_switch_dsc,
  output logic                    o_switch_pchg,
  output logic [MAX_CELLS-1:0]    o_bal,
  output logic [MAX_CELLS-1:0]    o_cell_needs_balance_flag,
  output logic [VW-1:0]           o_lowest_cell_voltage,
  output logic [VW-1:0]           o_highest_cell_voltage,
  output logic                    o_cell_spread_fault,
  output logic                    o_balance_undervolt_flag,
  output logic                    o_balance_overvolt_flag,
  output logic                    o_bal_on_period
);

  logic       rst_meta_ff;
  logic       rst_n_ff;
  pfb_state_t st_ff;
  pfb_state_t nxt_st;

  logic                 tick_us;
  logic                 tick_ms;
  logic                 tick_s;
  logic                 tick_min;
  logic                 tick_on;
  logic                 tick_off;
  logic [MAX_CELLS-1:0] used;
  logic [VW-1:0]        lo_now;
  logic [VW-1:0]        hi_now;
  logic [MAX_CELLS-1:0] needs_now;
  logic                 spread_now;
  logic                 temp_bad;
  logic                 dir_ok;
  logic                 bal_en;
  logic [VW:0]          floor_hi;
  logic [VW:0]          ceil_lo;

  // Reset is released through two flops so every state flop leaves reset on one edge.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // Time base ticks; each unit rolls over only on the tick of the unit below.
  assign tick_us  = (st_ff.cyc == 8'(CYC_PER_US - 1));
  assign tick_ms  = tick_us && (st_ff.us == 10'(US_PER_MS - 1));
  assign tick_s   = tick_ms && (st_ff.ms == 10'(MS_PER_S - 1));
  assign tick_min = tick_s && (st_ff.sec == 6'(S_PER_MIN - 1));

  function automatic logic pick_tick(input logic [1:0] scale, input logic us, input logic ms,
                                     input logic s, input logic mn);
    case (scale)
      SCALE_US: pick_tick = us;
      SCALE_MS: pick_tick = ms;
      SCALE_S:  pick_tick = s;
      default:  pick_tick = mn;
    endcase
  endfunction

  assign tick_on  = pick_tick(i_bal_cfg.on_scale, tick_us, tick_ms, tick_s, tick_min); // RULE22
  assign tick_off = pick_tick(i_bal_cfg.off_scale, tick_us, tick_ms, tick_s, tick_min); // RULE22

  // Scan statistics over the populated cells only; absent cells never count.
  always_comb begin
    lo_now     = LO_START;
    hi_now     = '0;
    needs_now  = '0;
    spread_now = 1'b0;
    used       = '0;
    for (int i = 0; i < MAX_CELLS; i++) begin
      used[i] = (4'(i) < i_cell_count); // RULE15
      if (used[i] && (i_cell_v[i] < lo_now)) begin
        lo_now = i_cell_v[i]; // RULE10
      end
      if (used[i] && (i_cell_v[i] > hi_now)) begin
        hi_now = i_cell_v[i]; // RULE10
      end
    end
    for (int i = 0; i < MAX_CELLS; i++) begin
      if (used[i] && ((i_cell_v[i] - lo_now) > i_bal_cfg.min_delta)) begin
        needs_now[i] = 1'b1; // RULE11
      end
      if (used[i] && ((i_cell_v[i] - lo_now) >= i_bal_cfg.max_delta)) begin
        spread_now = 1'b1; // RULE12
      end
    end
  end

  // A reading above the cold limit is too cold, below the hot limit too hot.
  always_comb begin
    temp_bad = 1'b0;
    for (int t = 0; t < N_TEMP; t++) begin
      if ((i_ext_temp[t*VW +: VW] > i_balance_cold_limit) ||
          (i_ext_temp[t*VW +: VW] < i_balance_hot_limit)) begin
        temp_bad = 1'b1; // RULE17 RULE23
      end
    end
  end

  // Balance permission: one current direction only, or the full-charge exception.
  assign dir_ok = (i_bal_cfg.in_chg && i_charging_detected && !i_discharging_detected) ||
                  (i_bal_cfg.in_dsc && i_discharging_detected && !i_charging_detected) ||
                  (i_bal_cfg.at_full && i_end_of_charge); // RULE18 RULE19 RULE20 RULE21
  assign bal_en = i_bal_enable && !i_host_scan_override && dir_ok && !st_ff.spread &&
                  !st_ff.uv && !st_ff.ov && !temp_bad && !i_force_switches_off_input &&
                  !i_sleep; // RULE9 RULE12 RULE13 RULE14 RULE17 RULE21

  assign floor_hi = {1'b0, i_bal_cfg.floor_v} + {1'b0, HYST_CODE};
  assign ceil_lo  = {1'b0, i_bal_cfg.ceiling_v} - {1'b0, HYST_CODE};

  // Next-state logic for switches, scan flags, time base and balance sequencer.
  always_comb begin
    nxt_st = st_ff;
    // Time base.
    nxt_st.cyc = tick_us ? '0 : st_ff.cyc + 8'h01;
    if (tick_us) begin
      nxt_st.us = tick_ms ? '0 : st_ff.us + 10'h001;
    end
    if (tick_ms) begin
      nxt_st.ms = tick_s ? '0 : st_ff.ms + 10'h001;
    end
    if (tick_s) begin
      nxt_st.sec = tick_min ? '0 : st_ff.sec + 6'h01;
    end

    // Pack switches. In host modes the register holds what the host wrote and
    // forced clears are sticky until the host writes again.
    if (i_host_switch_override || i_host_scan_override) begin
      if (i_host_sw_wr) begin
        nxt_st.sw = i_host_sw; // RULE1
      end
      if (i_short_circuit) begin
        nxt_st.sw = '0; // RULE2 RULE8
      end
      if (!i_host_scan_override) begin
        if (i_int_over_temp || i_open_wire) begin
          nxt_st.sw = '0; // RULE3 RULE5
        end
        if (i_overvoltage_lockout) begin
          nxt_st.sw.chg  = 1'b0; // RULE4
          nxt_st.sw.pchg = 1'b0; // RULE4
        end
      end
    end else begin
      nxt_st.sw.chg  = i_auto_sw_req.chg && !i_chg_temp_fault; // RULE23
      nxt_st.sw.pchg = i_auto_sw_req.pchg && !i_chg_temp_fault; // RULE23
      nxt_st.sw.dsc  = i_auto_sw_req.dsc && !i_dsc_temp_fault && !i_short_circuit; // RULE23
    end
    if (i_force_switches_off_input || i_sleep) begin
      nxt_st.sw = '0; // RULE6 RULE7
    end

    // Scan results are taken once per completed scan.
    if (i_scan_done) begin
      nxt_st.lo     = lo_now; // RULE10
      nxt_st.hi     = hi_now; // RULE10
      nxt_st.needs  = needs_now; // RULE11
      nxt_st.spread = spread_now; // RULE12
      if (hi_now < i_bal_cfg.floor_v) begin
        nxt_st.uv = 1'b1; // RULE13
      end else if ({1'b0, hi_now} > floor_hi) begin
        nxt_st.uv = 1'b0; // RULE13
      end
      if (lo_now > i_bal_cfg.ceiling_v) begin
        nxt_st.ov = 1'b1; // RULE14
      end else if ((i_bal_cfg.ceiling_v >= HYST_CODE) && ({1'b0, lo_now} < ceil_lo)) begin
        nxt_st.ov = 1'b0; // RULE14
      end
    end

    // Balance sequencer. Losing permission drops straight back to idle.
    case (st_ff.bst)
      BAL_IDLE: begin
        if (bal_en) begin
          nxt_st.bst = BAL_ON;
          nxt_st.tmr = {2'b00, i_bal_cfg.on_cnt}; // RULE22
          nxt_st.sel = st_ff.needs & used; // RULE16 RULE15
        end
      end
      BAL_ON: begin
        if (!bal_en) begin
          nxt_st.bst = BAL_IDLE;
        end else if (st_ff.tmr == 12'h000) begin
          nxt_st.bst = BAL_OFF;
          nxt_st.tmr = {2'b00, i_bal_cfg.off_cnt}; // RULE22
        end else if (tick_on) begin
          nxt_st.tmr = st_ff.tmr - 12'h001; // RULE22
        end
      end
      BAL_OFF: begin
        if (!bal_en) begin
          nxt_st.bst = BAL_IDLE;
        end else if (st_ff.tmr == 12'h000) begin
          nxt_st.bst = BAL_ON; // RULE24
          nxt_st.tmr = {2'b00, i_bal_cfg.on_cnt}; // RULE24
          nxt_st.sel = st_ff.needs & used; // RULE16
        end else if (tick_off) begin
          nxt_st.tmr = st_ff.tmr - 12'h001; // RULE22
        end
      end
      default: begin
        nxt_st.bst = BAL_IDLE;
      end
    endcase
    // Outputs follow the sequencer state so they can never lead the on period.
    nxt_st.bal = (nxt_st.bst == BAL_ON) ? nxt_st.sel : '0; // RULE9
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff <= '{sw: '0, bst: BAL_IDLE, lo: LO_START, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_switch_chg              = st_ff.sw.chg;
  assign o_switch_dsc              = st_ff.sw.dsc;
  assign o_switch_pchg             = st_ff.sw.pchg;
  assign o_bal                     = st_ff.bal;
  assign o_cell_needs_balance_flag = st_ff.needs;
  assign o_lowest_cell_voltage     = st_ff.lo;
  assign o_highest_cell_voltage    = st_ff.hi;
  assign o_cell_spread_fault       = st_ff.spread;
  assign o_balance_undervolt_flag  = st_ff.uv;
  assign o_balance_overvolt_flag   = st_ff.ov;
  assign o_bal_on_period           = (st_ff.bst == BAL_ON);

  // Checks on the registered outputs.
  sequence s_off_done;
    (st_ff.bst == BAL_OFF) && (st_ff.tmr == 12'h000) && bal_en;
  endsequence

  sequence s_on_run;
    (st_ff.bst == BAL_ON) ##1 (st_ff.bst == BAL_ON);
  endsequence

  force_off_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE6
    i_force_switches_off_input |=> (st_ff.sw == '0) && (st_ff.bal == '0))
    else $error("switches or balance on during force-off");

  short_off_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE8
    (i_host_scan_override && i_short_circuit) |=> (st_ff.sw == '0))
    else $error("switches on during short circuit");

  overvoltage_lockout_chg_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE4
    (i_host_switch_override && !i_host_scan_override && i_overvoltage_lockout)
    |=> !st_ff.sw.chg && !st_ff.sw.pchg)
    else $error("charge switch on during lockout");

  no_restore_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE2
    (i_host_switch_override && !st_ff.sw.dsc && !i_host_sw_wr) |=> !st_ff.sw.dsc)
    else $error("discharge switch restored without host write");

  off_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE9
    (st_ff.bst != BAL_ON) |-> (st_ff.bal == '0))
    else $error("balance output outside on period");

  sel_fixed_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE16
    s_on_run |-> $stable(st_ff.sel) && (st_ff.bal == st_ff.sel))
    else $error("balance selection changed in on period");

  off_to_on_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE24
    s_off_done |=> (st_ff.bst == BAL_ON) && (st_ff.tmr == {2'b00, $past(i_bal_cfg.on_cnt)}))
    else $error("on period not restarted after off period");

  spread_flag_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE12
    (i_scan_done && spread_now) |=> st_ff.spread ##1 (st_ff.bal == '0))
    else $error("spread fault not raised or balance not stopped");

  needs_scan_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE11
    i_scan_done |=> (st_ff.needs == $past(needs_now)) && (st_ff.lo == $past(lo_now)))
    else $error("scan results not captured");

  unused_cell_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE15
    (st_ff.bal & ~used) == '0 || $changed(i_cell_count))
    else $error("absent cell driven");

  disable_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_ff) // RULE21
    !bal_en |=> (st_ff.bal == '0) && (st_ff.bst == BAL_IDLE))
    else $error("balancing while not permitted");

endmodule
`default_nettype wire

// [verification/pfb_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host controller at the far side: it only ever writes the switch register with a strobe.
module pfb_host_model
  import pfb_pkg::*;
(
  input  wire logic    i_clk,
  output var logic     o_wr,
  output var pfb_sw_t  o_sw
);
  // Idle values at time zero, so the switch inputs are never unknown.
  initial begin
    o_wr = 1'b0;
    o_sw = 3'h0;
  end

  // One write, then the value bus is scrambled, so a design that samples it unstrobed fails.
  // Returns just after the edge that takes the write, so the caller sees the registered result.
  // In the host modes, the host alone switches the outputs back on after a forced clear.
  task automatic write_sw(input pfb_sw_t v);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_sw <= v;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_sw <= ~v;
    #1;
  endtask
endmodule
`default_nettype wire

// [verification/pfb_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pfb_top_tb
  import pfb_pkg::*;
;
  logic                clk;
  logic                rstn;
  logic                sw_ovr;
  logic                scan_ovr;
  pfb_sw_t             auto_req;
  logic                chg_tf;
  logic                dsc_tf;
  logic [5:0]          flt;
  logic                chg_det;
  logic                dsc_det;
  logic                eoc;
  logic                bal_en;
  logic                scan_done;
  logic [3:0]          ncell;
  pfb_cells_t          cells;
  logic [2*VW-1:0]     temps;
  pfb_bal_cfg_t        cfg;
  logic                host_wr;
  pfb_sw_t             host_sw;
  logic                sw_chg;
  logic                sw_dsc;
  logic                sw_pchg;
  logic [7:0]          bal;
  logic [7:0]          needs;
  logic [VW-1:0]       lo;
  logic [VW-1:0]       hi;
  logic                spread;
  logic                uv;
  logic                ov;
  logic                onp;
  int                  err_total;
  int                  checks_done;
  wire [2:0]           sw3 = {sw_chg, sw_dsc, sw_pchg};

  pfb_host_model pfb_host_model_inst (.i_clk(clk), .o_wr(host_wr), .o_sw(host_sw));

  // Fault inputs share one vector: short, over-temp, lockout, open wire, force-off, sleep.
  pfb_top #(.N_TEMP(2)) pfb_top_inst (
    .i_sys_clk(clk), .i_rstn(rstn), .i_host_switch_override(sw_ovr),
    .i_host_scan_override(scan_ovr), .i_host_sw_wr(host_wr), .i_host_sw(host_sw),
    .i_auto_sw_req(auto_req), .i_chg_temp_fault(chg_tf), .i_dsc_temp_fault(dsc_tf),
    .i_short_circuit(flt[0]), .i_int_over_temp(flt[1]), .i_overvoltage_lockout(flt[2]),
    .i_open_wire(flt[3]), .i_force_switches_off_input(flt[4]), .i_sleep(flt[5]),
    .i_charging_detected(chg_det), .i_discharging_detected(dsc_det),
    .i_end_of_charge(eoc), .i_bal_enable(bal_en), .i_cell_count(ncell),
    .i_scan_done(scan_done), .i_cell_v(cells), .i_ext_temp(temps),
    .i_balance_cold_limit(12'hC00), .i_balance_hot_limit(12'h400), .i_bal_cfg(cfg),
    .o_switch_chg(sw_chg), .o_switch_dsc(sw_dsc), .o_switch_pchg(sw_pchg), .o_bal(bal),
    .o_cell_needs_balance_flag(needs), .o_lowest_cell_voltage(lo),
    .o_highest_cell_voltage(hi), .o_cell_spread_fault(spread),
    .o_balance_undervolt_flag(uv), .o_balance_overvolt_flag(ov), .o_bal_on_period(onp));

  // The clock toggles every half period of 4 ns.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Comparison with case inequality, so an unknown never passes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  // Lands just after an edge, when the design's updates have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Four used cells; the absent ones hold extremes that would spoil min and max if read.
  function automatic pfb_cells_t mk(input logic [11:0] a, b, c, d);
    mk = {12'hF00, 12'h100, 12'hF00, 12'h100, d, c, b, a};
  endfunction

  // Cell values are valid only with the strobe, and scrambled otherwise.
  task automatic scan(input pfb_cells_t c);
    @(posedge clk);
    cells <= c;
    scan_done <= 1'b1;
    @(posedge clk);
    scan_done <= 1'b0;
    cells <= ~c;
    #1;
  endtask

  task automatic t_faults(input logic mode);
    logic [2:0] exp;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      sw_ovr <= ~mode;
      scan_ovr <= mode;
      pfb_host_model_inst.write_sw(3'h7);
      chk(sw3, 3'h7);
      exp = (mode == 1'b0) ? ((i == 2) ? 3'h2 : 3'h0) : ((i >= 1 && i <= 3) ? 3'h7 : 3'h0);
      @(posedge clk);
      flt <= 6'(1 << i);
      cyc(1);
      chk(sw3, exp);
      @(posedge clk);
      flt <= 6'h0;
      cyc(2);
      chk(sw3, exp);
    end
    $display("test faults mode %0d done", mode);
  endtask

  task automatic t_auto();
    @(posedge clk);
    sw_ovr <= 1'b0;
    scan_ovr <= 1'b0;
    auto_req <= 3'h7;
    cyc(2);
    chk(sw3, 3'h7);
    @(posedge clk);
    chg_tf <= 1'b1;
    cyc(1);
    chk(sw3[2:1], 2'b01);
    @(posedge clk);
    chg_tf <= 1'b0;
    dsc_tf <= 1'b1;
    cyc(1);
    chk(sw3[2:1], 2'b10);
    @(posedge clk);
    dsc_tf <= 1'b0;
    $display("test auto done");
  endtask

  // Boundaries: a delta equal to the minimum is not flagged, one equal to the maximum is.
  task automatic t_scan();
    scan(mk(12'h800, 12'h850, 12'h820, 12'h8A0));
    chk({lo, hi}, 24'h8008A0);
    chk({needs, spread}, 9'h014);
    // With three cells in use the fourth, lowest reading must be ignored.
    @(posedge clk);
    ncell <= 4'h3;
    scan(mk(12'h800, 12'h850, 12'h820, 12'h100));
    chk({lo, hi, needs}, 32'h80085002);
    @(posedge clk);
    ncell <= 4'h4;
    scan(mk(12'h800, 12'h850, 12'h820, 12'hA00));
    chk(spread, 1'b1);
    $display("test scan done");
  endtask

  task automatic t_uvov();
    logic [11:0] v;
    @(posedge clk);
    cfg.floor_v <= 12'h800;
    cfg.ceiling_v <= 12'h900;
    for (int i = 0; i < 6; i++) begin
      case (i)
        0: v = 12'h7FF;
        1: v = 12'h800 + HYST_CODE;
        2: v = 12'h801 + HYST_CODE;
        3: v = 12'h901;
        4: v = 12'h900 - HYST_CODE;
        default: v = 12'h8FF - HYST_CODE;
      endcase
      scan(mk(v, v, v, v));
      chk({uv, ov}, (i < 2) ? 2'b10 : ((i == 3 || i == 4) ? 2'b01 : 2'b00));
    end
    @(posedge clk);
    cfg.floor_v <= 12'h100;
    cfg.ceiling_v <= 12'hE00;
    $display("test hysteresis done");
  endtask

  // On period of three microsecond units, then a one unit off period.
  task automatic t_bal();
    int n;
    scan(mk(12'h800, 12'h850, 12'h820, 12'h8A0));
    @(posedge clk);
    bal_en <= 1'b1;
    for (n = 0; n < 10 && onp !== 1'b1; n++) cyc(1);
    chk({onp, bal}, 9'h10A);
    scan(mk(12'h800, 12'h800, 12'h850, 12'h800));
    chk(bal, 8'h0A);
    for (n = 3; n < 1000 && onp === 1'b1; n++) cyc(1);
    chk(n >= 480 && n <= 760, 1'b1);
    chk(bal, 8'h00);
    for (n = 0; n < 400 && onp !== 1'b1; n++) cyc(1);
    chk({onp, bal}, 9'h104);
    $display("test balance timing done");
  endtask

  task automatic t_dir();
    logic [5:0] k;
    @(posedge clk);
    cfg.on_cnt <= 10'h3FF;
    for (int i = 0; i < 64; i++) begin
      k = 6'(i);
      @(posedge clk);
      {eoc, cfg.at_full, dsc_det, chg_det, cfg.in_dsc, cfg.in_chg} <= k;
      cyc(4);
      chk(onp, (k[0] & k[2] & ~k[3]) | (k[1] & k[3] & ~k[2]) | (k[4] & k[5]));
    end
    $display("test direction table done");
  endtask

  task automatic t_block();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      if (i == 0) flt <= 6'h10;
      else if (i == 1) temps <= {12'h800, 12'hC01};
      else if (i == 2) temps <= {12'h3FF, 12'h800};
      if (i == 3) scan(mk(12'h800, 12'h850, 12'h820, 12'hA00));
      cyc(3);
      chk({onp, bal}, 9'h0);
      @(posedge clk);
      flt <= 6'h0;
      temps <= {12'h800, 12'h800};
      if (i == 3) scan(mk(12'h800, 12'h850, 12'h820, 12'h8A0));
      cyc(3);
      chk(onp, 1'b1);
    end
    $display("test balance blockers done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The run needs some 1500 cycles; forty times that means a hang.
  initial begin
    #240000;
    err_total++;
    wrap_up();
  end

  // Main sequence: reset values first, then each behaviour in turn.
  initial begin
    err_total = 0;
    checks_done = 0;
    rstn = 1'b0;
    {sw_ovr, scan_ovr, chg_tf, dsc_tf, chg_det, dsc_det, eoc, bal_en, scan_done} = 9'h0;
    auto_req = 3'h0;
    flt = 6'h0;
    ncell = 4'h4;
    cells = '0;
    temps = {12'h800, 12'h800};
    cfg = '{min_delta: 12'h20, max_delta: 12'h200, floor_v: 12'h100, ceiling_v: 12'hE00,
            on_cnt: 10'h3, on_scale: SCALE_US, off_cnt: 10'h1, off_scale: SCALE_US,
            in_chg: 1'b1, in_dsc: 1'b0, at_full: 1'b0};
    repeat (8) @(posedge clk);
    #1;
    chk({sw3, bal, needs, spread, uv, ov, onp}, 32'h0);
    chk({lo, hi}, 32'hFFF000);
    @(posedge clk);
    rstn <= 1'b1;
    cyc(4);
    t_faults(1'b0);
    t_faults(1'b1);
    t_auto();
    t_scan();
    t_uvov();
    @(posedge clk);
    chg_det <= 1'b1;
    t_bal();
    t_dir();
    @(posedge clk);
    {cfg.in_chg, chg_det} <= 2'b11;
    t_block();
    wrap_up();
  end
endmodule
`default_nettype wire
